// >>> rtl/aao_pkg.sv
package aao_pkg;

  localparam int DW = 8;
  localparam int MSB = 7;
  localparam int HALF_MSB = 3;

  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] BYTE_ONE  = 8'h01;
  localparam logic [DW-1:0] BYTE_ONES = 8'hFF;

  // status byte layout seen by the register file
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  localparam logic [DW-1:0] MASK_NONE  = 8'h00;
  localparam logic [DW-1:0] MASK_ZNV   = 8'h0E;
  localparam logic [DW-1:0] MASK_ZCNV  = 8'h0F;
  localparam logic [DW-1:0] MASK_ZCNVH = 8'h2F;
  localparam logic [DW-1:0] MASK_ZCNVS = 8'h1F;

  typedef enum logic [4:0] {
    OP_PLAIN_SUM, OP_CARRY_SUM, OP_WORD_SUM,
    OP_PLAIN_DIFF, OP_IMM_DIFF, OP_BORROW_DIFF, OP_BORROW_IMM_DIFF, OP_WORD_DIFF,
    OP_PLAIN_MASK, OP_IMM_MASK, OP_PLAIN_MERGE, OP_IMM_MERGE, OP_EXCL_MERGE,
    OP_BIT_SET, OP_BIT_CLEAR, OP_ONES_INVERT, OP_TWOS_INVERT,
    OP_STEP_UP, OP_STEP_DOWN, OP_ZERO_SIGN_CHECK, OP_REGISTER_ZERO, OP_REGISTER_FILL
  } aao_op_e;

  typedef enum logic [1:0] {LG_AND, LG_OR, LG_XOR} aao_logic_e;

  typedef enum logic {ST_IDLE, ST_WORD_HIGH} aao_state_e;

endpackage : aao_pkg

// >>> rtl/aao_unit_if.sv
`timescale 1ns/10ps
interface aao_unit_if;
  import aao_pkg::*;
  logic [DW-1:0] a;
  logic [DW-1:0] b;
  logic          cin;
  logic          sub;
  logic [DW-1:0] sum;
  logic          cout;
  logic          half;
  logic          ovf;
  logic [DW-1:0] la;
  logic [DW-1:0] lb;
  aao_logic_e    lop;
  logic [DW-1:0] lres;

  modport arith_unit (input a, b, cin, sub, output sum, cout, half, ovf);
  modport logic_unit (input la, lb, lop, output lres);
  modport core (output a, b, cin, sub, la, lb, lop, input sum, cout, half, ovf, lres);
endinterface : aao_unit_if

// >>> rtl/aao_adder8.sv
`timescale 1ns/10ps
module aao_adder8
  import aao_pkg::*;
(
  aao_unit_if.arith_unit u
);
  // subtract as a + ~b + ~borrow; the raw carry is the inverted borrow, so cout inverts it back to the borrow
  wire logic [DW-1:0] b_eff   = u.b ^ {DW{u.sub}};
  wire logic          cin_eff = u.cin ^ u.sub;
  wire logic [4:0]    low     = {1'b0, u.a[HALF_MSB:0]} + {1'b0, b_eff[HALF_MSB:0]} + {4'h0, cin_eff};
  wire logic [4:0]    high    = {1'b0, u.a[MSB:HALF_MSB+1]} + {1'b0, b_eff[MSB:HALF_MSB+1]} + {4'h0, low[4]};

  assign u.sum  = {high[3:0], low[3:0]};
  assign u.cout = high[4] ^ u.sub;
  assign u.half = low[4] ^ u.sub;
  assign u.ovf  = (u.a[MSB] & b_eff[MSB] & ~u.sum[MSB]) | (~u.a[MSB] & ~b_eff[MSB] & u.sum[MSB]);
endmodule : aao_adder8

// >>> rtl/aao_logic8.sv
`timescale 1ns/10ps
module aao_logic8
  import aao_pkg::*;
(
  aao_unit_if.logic_unit u
);
  genvar i;
  generate
    for (i = 0; i < DW; i++) begin : g_bit
      assign u.lres[i] = (u.lop == LG_AND) ? (u.la[i] & u.lb[i]) :
                         (u.lop == LG_OR)  ? (u.la[i] | u.lb[i]) :
                                             (u.la[i] ^ u.lb[i]);
    end
  endgenerate
endmodule : aao_logic8

// >>> rtl/aao_alu_core.sv
`timescale 1ns/10ps
// Overview of operation
// - carry sum adds source, destination and carry in one clock, updating Z,C,N,V,H.
// - word immediate sum adds the constant to the register pair over two clocks, updating Z,C,N,V,S.
// - immediate difference subtracts the constant from destination in one clock, updating Z,C,N,V,H.
// - borrow difference computes destination minus source minus carry in one clock, updating Z,C,N,V,H.
// - borrow immediate difference computes destination minus constant minus carry in one clock, Z,C,N,V,H.
// - word immediate difference subtracts the constant from the pair over two clocks, updating Z,C,N,V,S.
// - immediate mask ANDs destination with the constant in one clock, updating only Z,N,V.
// - immediate merge and bit set OR destination with the constant in one clock, updating Z,N,V.
// - bit clear ANDs destination with all-ones minus the constant in one clock, updating Z,N,V.
// - zero/sign check ANDs destination with itself, leaving it unchanged, updating Z,N,V in one clock.
// - ones invert writes all-ones minus destination in one clock, updating Z,C,N,V.
// - twos invert writes zero minus destination modulo 256 in one clock, updating Z,C,N,V,H.
// - register zero XORs destination with itself in one clock, updating Z,N,V.
module aao_alu_core
  import aao_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          op_valid,
  output wire logic          op_ready,
  input  wire aao_op_e       op_code,
  input  wire logic [DW-1:0] dest_val,
  input  wire logic [DW-1:0] src_val,
  input  wire logic [DW-1:0] imm_val,
  input  wire logic [DW-1:0] pair_low_val,
  input  wire logic [DW-1:0] pair_high_val,
  input  wire logic [DW-1:0] sreg_in,
  output logic               done_q,
  output logic               dest_we_q,
  output logic [DW-1:0]      dest_data_q,
  output logic               pair_we_q,
  output logic [2*DW-1:0]    pair_data_q,
  output logic [DW-1:0]      sreg_out_q,
  output logic [DW-1:0]      flag_we_q
);

  aao_unit_if u_if ();

  aao_adder8 u_add (.u(u_if));
  aao_logic8 u_log (.u(u_if));

  aao_state_e    state_q;
  aao_state_e    state_d;
  logic [DW-1:0] lo_q;
  logic          carry_lo_q;
  logic [DW-1:0] pair_hi_q;
  logic          word_sub_q;
  logic [DW-1:0] sreg_base_q;

  wire logic hi_phase = (state_q == ST_WORD_HIGH);
  wire logic take     = op_valid && op_ready;
  assign op_ready = !hi_phase;

  wire logic is_word  = op_code inside {OP_WORD_SUM, OP_WORD_DIFF};
  wire logic is_sub   = op_code inside {OP_PLAIN_DIFF, OP_IMM_DIFF, OP_BORROW_DIFF, OP_BORROW_IMM_DIFF,
                                        OP_WORD_DIFF, OP_TWOS_INVERT, OP_STEP_DOWN};
  wire logic is_chain = op_code inside {OP_CARRY_SUM, OP_BORROW_DIFF, OP_BORROW_IMM_DIFF};
  wire logic is_reg_b = op_code inside {OP_PLAIN_SUM, OP_CARRY_SUM, OP_PLAIN_DIFF, OP_BORROW_DIFF,
                                        OP_PLAIN_MASK, OP_PLAIN_MERGE, OP_EXCL_MERGE};
  wire logic is_step  = op_code inside {OP_STEP_UP, OP_STEP_DOWN};
  wire logic is_self  = op_code inside {OP_ZERO_SIGN_CHECK, OP_REGISTER_ZERO};
  wire logic is_and   = op_code inside {OP_PLAIN_MASK, OP_IMM_MASK, OP_BIT_CLEAR, OP_ZERO_SIGN_CHECK};
  wire logic is_or    = op_code inside {OP_PLAIN_MERGE, OP_IMM_MERGE, OP_BIT_SET};
  wire logic is_xor   = op_code inside {OP_EXCL_MERGE, OP_ONES_INVERT, OP_REGISTER_ZERO};
  wire logic is_logic = is_and || is_or || is_xor;
  wire logic is_ones  = (op_code == OP_ONES_INVERT);
  wire logic is_twos  = (op_code == OP_TWOS_INVERT);
  wire logic is_bclr  = (op_code == OP_BIT_CLEAR);
  wire logic is_fill  = (op_code == OP_REGISTER_FILL);

  // adder operands; the second word cycle ignores the decoder entirely
  assign u_if.a   = hi_phase ? pair_hi_q :
                    is_twos  ? BYTE_ZERO :
                    is_word  ? pair_low_val : dest_val;
  assign u_if.b   = hi_phase ? BYTE_ZERO :
                    is_twos  ? dest_val :
                    is_step  ? BYTE_ONE :
                    is_reg_b ? src_val : imm_val;
  assign u_if.cin = hi_phase ? carry_lo_q : (is_chain && sreg_in[FLAG_C]);
  assign u_if.sub = hi_phase ? word_sub_q : is_sub;

  assign u_if.la  = dest_val;
  assign u_if.lb  = is_self ? dest_val :
                    is_ones ? BYTE_ONES :
                    is_bclr ? BYTE_ONES - imm_val :
                    is_reg_b ? src_val : imm_val;
  assign u_if.lop = is_and ? LG_AND : is_or ? LG_OR : LG_XOR;

  wire logic [DW-1:0] res_byte = is_fill  ? BYTE_ONES :
                                 is_logic ? u_if.lres : u_if.sum;

  // pair result is zero only when both halves are
  wire logic z_byte = (res_byte == BYTE_ZERO);
  wire logic z_word = (u_if.sum == BYTE_ZERO) && (lo_q == BYTE_ZERO);
  wire logic n_flag = hi_phase ? u_if.sum[MSB] : res_byte[MSB];
  wire logic v_flag = (is_logic && !hi_phase) ? 1'b0 : u_if.ovf;
  wire logic c_flag = (is_ones && !hi_phase) ? 1'b1 : u_if.cout;

  logic [DW-1:0] flags_new;
  always_comb begin
    flags_new         = BYTE_ZERO;
    flags_new[FLAG_C] = c_flag;
    flags_new[FLAG_Z] = hi_phase ? z_word : z_byte;
    flags_new[FLAG_N] = n_flag;
    flags_new[FLAG_V] = v_flag;
    flags_new[FLAG_S] = n_flag ^ v_flag;
    flags_new[FLAG_H] = u_if.half;
  end

  wire logic [DW-1:0] flag_mask = hi_phase ? MASK_ZCNVS :
                                  is_fill  ? MASK_NONE :
                                  is_ones  ? MASK_ZCNV :
                                  (is_logic || is_step) ? MASK_ZNV :
                                  MASK_ZCNVH;
  wire logic [DW-1:0] sreg_base = hi_phase ? sreg_base_q : sreg_in;
  wire logic [DW-1:0] sreg_next = (sreg_base & ~flag_mask) | (flags_new & flag_mask);
  wire logic          byte_done = take && !is_word;
  wire logic          word_low  = take && is_word;

  always_comb begin
    case (state_q)
      ST_IDLE:      state_d = word_low ? ST_WORD_HIGH : ST_IDLE;
      ST_WORD_HIGH: state_d = ST_IDLE;
      default:      state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      lo_q        <= BYTE_ZERO;
      carry_lo_q  <= 1'b0;
      pair_hi_q   <= BYTE_ZERO;
      word_sub_q  <= 1'b0;
      sreg_base_q <= BYTE_ZERO;
    end else begin
      state_q <= state_d;
      if (word_low) begin
        lo_q        <= u_if.sum;
        carry_lo_q  <= u_if.cout;
        pair_hi_q   <= pair_high_val;
        word_sub_q  <= is_sub;
        sreg_base_q <= sreg_in;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_q      <= 1'b0;
      dest_we_q   <= 1'b0;
      dest_data_q <= BYTE_ZERO;
      pair_we_q   <= 1'b0;
      pair_data_q <= {BYTE_ZERO, BYTE_ZERO};
      sreg_out_q  <= BYTE_ZERO;
      flag_we_q   <= MASK_NONE;
    end else begin
      done_q    <= byte_done || hi_phase;
      dest_we_q <= byte_done;
      pair_we_q <= hi_phase;
      flag_we_q <= (byte_done || hi_phase) ? flag_mask : MASK_NONE;
      if (byte_done) begin
        dest_data_q <= res_byte;
      end
      if (hi_phase) begin
        pair_data_q <= {u_if.sum, lo_q};
      end
      if (byte_done || hi_phase) begin
        sreg_out_q <= sreg_next;
      end
    end
  end

  // reference values for the checks below
  wire logic [DW-1:0]   cin_ext  = {{(DW-1){1'b0}}, sreg_in[FLAG_C]};
  wire logic [DW-1:0]   ref_adc  = dest_val + src_val + cin_ext;
  wire logic [DW-1:0]   ref_sbc  = dest_val - src_val - cin_ext;
  wire logic [DW-1:0]   ref_borrow_immediate_difference_op = dest_val - imm_val - cin_ext;
  wire logic [2*DW-1:0] pair_in  = {pair_high_val, pair_low_val};
  wire logic [2*DW-1:0] ref_wadd = pair_in + {BYTE_ZERO, imm_val};
  wire logic [2*DW-1:0] ref_wsub = pair_in - {BYTE_ZERO, imm_val};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_take(aao_op_e op);
    take && op_code == op;
  endsequence
  sequence s_word_steps;
    !op_ready ##1 done_q && pair_we_q && !dest_we_q && flag_we_q == MASK_ZCNVS;
  endsequence

  property p_carry_sum;
    s_take(OP_CARRY_SUM) |=> done_q && dest_data_q == $past(ref_adc) && flag_we_q == MASK_ZCNVH;
  endproperty
  a_carry_sum: assert property (p_carry_sum) else $error("carry sum wrong");

  property p_word_sum;
    s_take(OP_WORD_SUM) |=> s_word_steps ##0 pair_data_q == $past(ref_wadd, 2);
  endproperty
  a_word_sum: assert property (p_word_sum) else $error("word sum wrong");

  property p_imm_diff;
    s_take(OP_IMM_DIFF) |=> dest_data_q == $past(dest_val - imm_val) && flag_we_q == MASK_ZCNVH;
  endproperty
  a_imm_diff: assert property (p_imm_diff) else $error("immediate difference wrong");

  property p_borrow_diff;
    s_take(OP_BORROW_DIFF) |=> dest_data_q == $past(ref_sbc)
      && sreg_out_q[FLAG_C] == ({1'b0, $past(dest_val)} < {1'b0, $past(src_val)} + $past(cin_ext));
  endproperty
  a_borrow_diff: assert property (p_borrow_diff) else $error("borrow difference wrong");

  property p_borrow_imm;
    s_take(OP_BORROW_IMM_DIFF) |=> dest_we_q && dest_data_q == $past(ref_borrow_immediate_difference_op);
  endproperty
  a_borrow_imm: assert property (p_borrow_imm) else $error("borrow immediate wrong");

  property p_word_diff;
    s_take(OP_WORD_DIFF) |=> s_word_steps ##0 pair_data_q == $past(ref_wsub, 2)
      && sreg_out_q[FLAG_S] == (sreg_out_q[FLAG_N] ^ sreg_out_q[FLAG_V]);
  endproperty
  a_word_diff: assert property (p_word_diff) else $error("word difference wrong");

  property p_imm_mask;
    s_take(OP_IMM_MASK) |=> dest_data_q == $past(dest_val & imm_val) && flag_we_q == MASK_ZNV
      && !sreg_out_q[FLAG_V];
  endproperty
  a_imm_mask: assert property (p_imm_mask) else $error("immediate mask wrong");

  property p_merge;
    (s_take(OP_IMM_MERGE) or s_take(OP_BIT_SET)) |=> dest_data_q == $past(dest_val | imm_val);
  endproperty
  a_merge: assert property (p_merge) else $error("merge wrong");

  property p_bit_clear;
    s_take(OP_BIT_CLEAR) |=> dest_data_q == $past(dest_val & ~imm_val) && flag_we_q == MASK_ZNV;
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

  property p_zero_check;
    s_take(OP_ZERO_SIGN_CHECK) |=> dest_data_q == $past(dest_val)
      && sreg_out_q[FLAG_N] == dest_data_q[MSB];
  endproperty
  a_zero_check: assert property (p_zero_check) else $error("zero check wrong");

  property p_ones;
    s_take(OP_ONES_INVERT) |=> dest_data_q == $past(~dest_val) && sreg_out_q[FLAG_C]
      && flag_we_q == MASK_ZCNV;
  endproperty
  a_ones: assert property (p_ones) else $error("ones invert wrong");

  property p_twos;
    s_take(OP_TWOS_INVERT) |=> dest_data_q == $past(BYTE_ZERO - dest_val)
      && sreg_out_q[FLAG_C] == (dest_data_q != BYTE_ZERO);
  endproperty
  a_twos: assert property (p_twos) else $error("twos invert wrong");

  property p_reg_zero;
    s_take(OP_REGISTER_ZERO) |=> dest_data_q == BYTE_ZERO && sreg_out_q[FLAG_Z];
  endproperty
  a_reg_zero: assert property (p_reg_zero) else $error("register zero wrong");

  property p_reg_ops;
    s_take(OP_PLAIN_SUM) |=> done_q && op_ready && dest_data_q == $past(dest_val + src_val);
  endproperty
  a_reg_ops: assert property (p_reg_ops) else $error("register sum wrong");

  property p_fill;
    s_take(OP_REGISTER_FILL) |=> dest_data_q == BYTE_ONES && flag_we_q == MASK_NONE
      && sreg_out_q == $past(sreg_in);
  endproperty
  a_fill: assert property (p_fill) else $error("register fill wrong");

  // nine-bit compare so a full source plus carry still counts as a carry out
  property p_carry_out;
    s_take(OP_CARRY_SUM) |=> sreg_out_q[FLAG_C] ==
      ({1'b0, $past(dest_val)} + {1'b0, $past(src_val)} + $past(cin_ext) > {1'b0, BYTE_ONES});
  endproperty
  a_carry_out: assert property (p_carry_out) else $error("carry sum carry wrong");

  property p_plain_diff;
    s_take(OP_PLAIN_DIFF) |=> dest_data_q == $past(dest_val - src_val) && flag_we_q == MASK_ZCNVH;
  endproperty
  a_plain_diff: assert property (p_plain_diff) else $error("register difference wrong");

  property p_reg_logic;
    (s_take(OP_PLAIN_MASK) or s_take(OP_PLAIN_MERGE) or s_take(OP_EXCL_MERGE))
      |=> done_q && flag_we_q == MASK_ZNV && !sreg_out_q[FLAG_V];
  endproperty
  a_reg_logic: assert property (p_reg_logic) else $error("register logic wrong");

  property p_step_up;
    s_take(OP_STEP_UP) |=> dest_data_q == $past(dest_val + BYTE_ONE) && flag_we_q == MASK_ZNV;
  endproperty
  a_step_up: assert property (p_step_up) else $error("step up wrong");

  property p_step_down;
    s_take(OP_STEP_DOWN) |=> dest_data_q == $past(dest_val - BYTE_ONE) && flag_we_q == MASK_ZNV;
  endproperty
  a_step_down: assert property (p_step_down) else $error("step down wrong");

endmodule : aao_alu_core

// >>> dv/aao_rf_model.sv
`timescale 1ns/10ps
module aao_rf_model
  import aao_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          done_q,
  input  wire logic [DW-1:0] sreg_out_q,
  input  wire logic [DW-1:0] flag_we_q,
  output logic      [DW-1:0] stat_q
);
  // only flags named in the write mask change, as the real status register would
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= BYTE_ZERO;
    end else if (done_q) begin
      stat_q <= (stat_q & ~flag_we_q) | (sreg_out_q & flag_we_q);
    end
  end
endmodule : aao_rf_model

// >>> dv/aao_alu_core_test.sv
`timescale 1ns/10ps
module aao_alu_core_test;
  import aao_pkg::*;
  typedef struct {
    logic        word;
    logic [15:0] data;
    logic [7:0]  sreg;
    logic [7:0]  mask;
    int          at;
  } aao_exp_s;
  logic          mclk, rst_n, op_valid, chain, op_ready, done_q, dest_we_q, pair_we_q;
  aao_op_e       op_code;
  logic [DW-1:0] dest_val, src_val, imm_val, pair_low_val, pair_high_val, sreg_drv;
  logic [DW-1:0] dest_data_q, sreg_out_q, flag_we_q, rf_stat, stat_m;
  logic [15:0]   pair_data_q;
  wire  [DW-1:0] sreg_in = chain ? rf_stat : sreg_drv;
  aao_exp_s      notes[$];
  aao_exp_s      me;
  int            cyc, error_cnt, total_checks, seed;

  aao_alu_core aao_alu_core_i (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .dest_val(dest_val), .src_val(src_val), .imm_val(imm_val),
    .pair_low_val(pair_low_val), .pair_high_val(pair_high_val), .sreg_in(sreg_in), .done_q(done_q),
    .dest_we_q(dest_we_q), .dest_data_q(dest_data_q), .pair_we_q(pair_we_q), .pair_data_q(pair_data_q),
    .sreg_out_q(sreg_out_q), .flag_we_q(flag_we_q));
  aao_rf_model aao_rf_model_i (.mclk(mclk), .rst_n(rst_n), .done_q(done_q), .sreg_out_q(sreg_out_q),
    .flag_we_q(flag_we_q), .stat_q(rf_stat));

  task automatic chk(logic [31:0] seen, logic [31:0] exp, string msg);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  function automatic aao_exp_s calc(aao_op_e op, logic [7:0] d, s, k, pl, ph, sr);
    aao_exp_s    e;
    logic [7:0]  a, b, r, f;
    logic [8:0]  r9;
    logic [4:0]  h5;
    logic [16:0] w;
    logic        ci, sb, ar;
    {a, b, ci, sb, ar} = {d, s, 1'b0, 1'b0, 1'b1};
    {e.word, e.mask, f, r} = {1'b0, MASK_ZCNVH, BYTE_ZERO, BYTE_ZERO};
    case (op)
      OP_CARRY_SUM:       ci = sr[FLAG_C];
      OP_PLAIN_DIFF:      sb = 1'b1;
      OP_IMM_DIFF:        {b, sb} = {k, 1'b1};
      OP_BORROW_DIFF:     {ci, sb} = {sr[FLAG_C], 1'b1};
      OP_BORROW_IMM_DIFF: {b, ci, sb} = {k, sr[FLAG_C], 1'b1};
      OP_TWOS_INVERT:     {a, b, sb} = {BYTE_ZERO, d, 1'b1};
      OP_STEP_UP:         {b, e.mask} = {BYTE_ONE, MASK_ZNV};
      OP_STEP_DOWN:       {b, sb, e.mask} = {BYTE_ONE, 1'b1, MASK_ZNV};
      OP_WORD_SUM, OP_WORD_DIFF: {sb, e.word, e.mask} = {op == OP_WORD_DIFF, 1'b1, MASK_ZCNVS};
      OP_PLAIN_SUM:       ar = 1'b1;
      default:            ar = 1'b0;
    endcase
    r9 = sb ? {1'b0, a} - b - ci : {1'b0, a} + b + ci;
    h5 = sb ? {1'b0, a[3:0]} - b[3:0] - ci : {1'b0, a[3:0]} + b[3:0] + ci;
    w  = sb ? {1'b0, ph, pl} - k : {1'b0, ph, pl} + k;
    if (ar) begin
      {f[FLAG_C], r, f[FLAG_H]} = {r9, h5[4]};
      f[FLAG_V] = ((a[7] ^ b[7]) == sb) && (r[7] != a[7]);
    end else begin
      e.mask = MASK_ZNV;
      case (op)
        OP_PLAIN_MASK:      r = d & s;
        OP_IMM_MASK:        r = d & k;
        OP_PLAIN_MERGE:     r = d | s;
        OP_EXCL_MERGE:      r = d ^ s;
        OP_BIT_CLEAR:       r = d & (BYTE_ONES - k);
        OP_ZERO_SIGN_CHECK: r = d & d;
        OP_REGISTER_ZERO:   r = d ^ d;
        OP_ONES_INVERT:     {r, f[FLAG_C], e.mask} = {BYTE_ONES - d, 1'b1, MASK_ZCNV};
        OP_REGISTER_FILL:   {r, e.mask} = {BYTE_ONES, MASK_NONE};
        default:            r = d | k;
      endcase
    end
    {f[FLAG_N], f[FLAG_Z]} = {r[7], r == BYTE_ZERO};
    if (e.word) begin
      {f[FLAG_C], f[FLAG_N], f[FLAG_Z]} = {w[16], w[15], w[15:0] == 16'h0000};
      f[FLAG_V] = (ph[7] == sb) && (w[15] != ph[7]);
    end
    f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
    e.data = e.word ? w[15:0] : {8'h00, r};
    e.sreg = (sr & ~e.mask) | (f & e.mask);
    return e;
  endfunction : calc

  // holds the request until op_ready is seen high at a falling edge, then waits for the next rising (take) edge
  task automatic issue(aao_op_e op, logic [7:0] d, s, k, pl, ph, sr);
    aao_exp_s e;
    int       n;
    e = calc(op, d, s, k, pl, ph, chain ? stat_m : sr);
    op_code <= op;
    {op_valid, dest_val, src_val} <= {1'b1, d, s};
    {imm_val, pair_low_val, pair_high_val, sreg_drv} <= {k, pl, ph, sr};
    n = 0;
    @(negedge mclk);
    while (op_ready !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if (op_ready !== 1'b1) begin
      chk(1, 0, "op never taken");
      close_out();
    end
    e.at = cyc + (e.word ? 2 : 1);
    notes.push_back(e);
    @(posedge mclk);
  endtask : issue

  task automatic idle(int c);
    op_valid <= 1'b0;
    repeat (c) @(posedge mclk);
  endtask : idle

  task automatic drain;
    int n;
    n = 0;
    op_valid <= 1'b0;
    while (notes.size() != 0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (notes.size() != 0) begin
      chk(1, 0, "result missing");
      close_out();
    end
    idle(1);
  endtask : drain

  task automatic chk_reset;
    @(negedge mclk);
    chk(op_ready, 1'b1, "ready in reset");
    chk({done_q, dest_we_q, pair_we_q, flag_we_q}, 0, "pulses in reset");
    chk({dest_data_q, pair_data_q, sreg_out_q}, 0, "data in reset");
  endtask : chk_reset

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  always @(negedge mclk) begin
    if (done_q === 1'b1 && notes.size() == 0) begin
      chk(1, 0, "unexpected result");
    end else if (done_q === 1'b1) begin
      me = notes.pop_front();
      chk(cyc, me.at, "latency");
      chk({pair_we_q, dest_we_q}, {me.word, !me.word}, "write strobes");
      chk(me.word ? pair_data_q : {8'h00, dest_data_q}, me.data, "result");
      chk(sreg_out_q, me.sreg, "status");
      chk(flag_we_q, me.mask, "flag mask");
      stat_m = (stat_m & ~me.mask) | (me.sreg & me.mask);
    end else begin
      chk(flag_we_q, MASK_NONE, "stray mask");
    end
  end

  initial begin
    {rst_n, op_valid, chain} = 3'h0;
    stat_m = BYTE_ZERO;
    op_code = OP_PLAIN_SUM;
    {dest_val, src_val, imm_val, pair_low_val, pair_high_val, sreg_drv} = '0;
    seed = $urandom(67);
    repeat (10) @(posedge mclk);
    chk_reset();
    @(posedge mclk);
    rst_n <= 1'b1;
    issue(OP_STEP_UP, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(OP_STEP_DOWN, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
    issue(OP_WORD_SUM, 8'h00, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00);
    issue(OP_TWOS_INVERT, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(OP_WORD_DIFF, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hC0);
    issue(OP_WORD_SUM, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h7F, 8'hFF);
    issue(OP_TWOS_INVERT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
    issue(OP_IMM_DIFF, 8'h5A, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00);
    issue(OP_CARRY_SUM, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
    issue(OP_ONES_INVERT, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    issue(OP_REGISTER_FILL, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC5);
    issue(OP_BIT_CLEAR, 8'hF0, 8'h00, 8'hF0, 8'h00, 8'h00, 8'h3A);
    drain();
    $display("test corners done");
    for (int rep = 0; rep < 20; rep++) begin
      for (int o = 0; o < 22; o++) begin
        issue(aao_op_e'(o), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
        if ($urandom_range(3) == 0) idle(1);
      end
    end
    drain();
    $display("test sweep done");
    chain <= 1'b1;
    idle(1);
    for (int i = 0; i < 40; i++) begin
      issue(aao_op_e'(i % 3 == 0 ? OP_CARRY_SUM : i % 3 == 1 ? OP_BORROW_DIFF : OP_BORROW_IMM_DIFF),
            8'($urandom), 8'($urandom), 8'($urandom), 8'h00, 8'h00, 8'h00);
      idle(1);
    end
    drain();
    chain <= 1'b0;
    $display("test carry chain done");
    rst_n <= 1'b0;
    chk_reset();
    notes.delete();
    stat_m = BYTE_ZERO;
    @(posedge mclk);
    rst_n <= 1'b1;
    issue(OP_PLAIN_SUM, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
    drain();
    $display("test mid reset done");
    close_out();
  end
endmodule : aao_alu_core_test
